// ==== core/opcode_cmd_map.vh ====
// register offsets, opcodes, point and condition codes for the command interpreter
`ifndef OPCODE_CMD_MAP_VH
`define OPCODE_CMD_MAP_VH
`define REG_ACTION_OPCODE 16'h9cbd
`define REG_ACTION_PARAM_ONE 16'h9cbe
`define REG_ACTION_PARAM_TWO 16'h9cbf
`define OP_ALARM_CLEAR 8'hba
`define OP_JOG_BEGIN 8'h96
`define OP_JOG_HALT 8'hd8
`define OP_ENCODER_POS_LOAD 8'h98
`define OP_FIXED_MOVE_SPEED_CHANGE 8'h6d
`define OP_RELATIVE_MOVE 8'h66
`define OP_SENSOR_MOVE_MASKED 8'h6a
`define OP_FIXED_MOVE_WITH_OUTPUT 8'h68
`define OP_ABSOLUTE_MOVE 8'h67
`define OP_SENSOR_MOVE 8'h6b
`define OP_SENSOR_MOVE_SAFETY 8'h6c
`define OP_MOTOR_OFF 8'h9e
`define OP_MOTOR_ON 8'h9f
`define OP_ORIGIN_SEEK 8'h6e
`define OP_POSITION_LOAD 8'ha5
`define OP_CLOSED_LOOP_SWITCH 8'h54
`define OP_SET_OUTPUT 8'h8b
`define OP_INPUT_WAIT 8'h70
`define OP_PROGRAM_RUN 8'h78
`define OP_TIME_WAIT 8'h6f
`define OP_ORIGIN_FIND_ALT 8'hdb
`define OP_HARD_STOP_FLUSH 8'he1
`define OP_SOFT_STOP_FLUSH 8'he2
`define CMD_COUNT 23
`define CLOSED_LOOP_MODE_FULL 16'h0001
`define PT_INDEX 8'h30
`define PT_PORT_FIRST 8'h31
`define PT_PORT_LAST 8'h3c
`define COND_LOW 8'h4c
`define COND_HIGH 8'h48
`define COND_RISE 8'h52
`define COND_FALL 8'h46
`define COND_NONE 3'b000
`define COND_IS_LOW 3'b001
`define COND_IS_HIGH 3'b010
`define COND_IS_RISE 3'b011
`define COND_IS_FALL 3'b100
`endif

// ==== core/io_code_decode.v ====
// decoder of I/O point and condition codes
`timescale 1ns/1ps
module io_code_decode (
    input wire [15:0] point_code,
    input wire [15:0] cond_code,
    output reg [3:0] point_index,
    output reg point_valid,
    output reg [2:0] cond_kind
);
`include "opcode_cmd_map.vh"
    // index 0 is the encoder index pulse, 1..12 the ports
    always @* begin
        point_index = 4'h0;
        point_valid = 1'b0;
        if (point_code[15:8] == 8'h00 && point_code[7:0] >= `PT_INDEX &&
                point_code[7:0] <= `PT_PORT_LAST) begin
            point_index = point_code[3:0];
            point_valid = 1'b1;
        end
    end

    always @* begin
        cond_kind = `COND_NONE;
        if (cond_code[15:8] == 8'h00) begin
            case (cond_code[7:0])
                `COND_LOW: cond_kind = `COND_IS_LOW;
                `COND_HIGH: cond_kind = `COND_IS_HIGH;
                `COND_RISE: cond_kind = `COND_IS_RISE;
                `COND_FALL: cond_kind = `COND_IS_FALL;
                default: cond_kind = `COND_NONE;
            endcase
        end
    end
endmodule // io_code_decode

// ==== core/opcode_cmd_interp.v ====
// command interpreter: opcode register, two parameters, one-cycle command strobes
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - register 40125 (0x9cbd) holds the action opcode.
// - each write to the opcode register launches the matching action.
// - parameters one and two live at 40126 and 40127.
// - parameter slots an opcode does not use are ignored.
// - 0x96 starts continuous jog, no parameters.
// - 0xd8 stops jog, no parameters.
// - 0x66 relative move, 0x67 absolute move, no parameters.
// - 0x6b, 0x6a, 0x6c sensor moves take point and condition.
// - 0x68 move with output, 0x6d move with speed change take point, condition.
// - 0x6e origin seek ends on given point and condition.
// - 0xdb alternate homing takes one parameter.
// - 0xa5 loads commanded position, 0x98 encoder position, split over both.
// - 0x8b drives output named by point to state given by condition.
// - 0x70 waits for a digital input condition; the code decodes no point or condition for it.
// - 0x78 runs stored program selected by parameter one.
// - 0xe1 stops at max deceleration and flushes buffered commands.
// - 0xe2 stops at normal deceleration and flushes buffered commands.
// - 0x54 with parameter one 01 switches to full closed loop.
// - point codes: 0x30 index pulse, 0x31..0x3c ports one to twelve.
// - condition 0x4c means low level, optocoupler conducting.
// - condition 0x48 means high level, optocoupler off.
module opcode_cmd_interp (
    input wire ref_clk,
    input wire reset_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output reg reg_ack,
    output reg reg_err,
    output reg alarm_clear_cmd,
    output reg jog_begin_cmd,
    output reg jog_halt_cmd,
    output reg encoder_pos_load_cmd,
    output reg fixed_move_speed_change_cmd,
    output reg relative_move_cmd,
    output reg sensor_move_masked_cmd,
    output reg fixed_move_with_output_cmd,
    output reg absolute_move_cmd,
    output reg sensor_move_cmd,
    output reg sensor_move_safety_cmd,
    output reg motor_off_cmd,
    output reg motor_on_cmd,
    output reg origin_seek_cmd,
    output reg position_load_cmd,
    output reg closed_loop_switch_cmd,
    output reg set_output_cmd,
    output reg input_wait_cmd,
    output reg program_run_cmd,
    output reg time_wait_cmd,
    output reg origin_find_alt_cmd,
    output reg hard_stop_flush_cmd,
    output reg soft_stop_flush_cmd,
    output reg [3:0] cmd_point,
    output reg [2:0] cmd_cond,
    output reg [15:0] cmd_value,
    output reg [31:0] cmd_position,
    output reg opcode_rejected
);
`include "opcode_cmd_map.vh"

    //////////////////////////////////////////////////////////////////////////
    // registers
    reg [15:0] action_opcode;
    reg [15:0] action_param_one;
    reg [15:0] action_param_two;
    reg launch;
    reg [15:0] launch_opcode;
    wire [3:0] dec_point;
    wire dec_point_valid;
    wire [2:0] dec_cond;
    reg [22:0] next_cmd;
    reg next_reject;
    reg uses_point;
    reg uses_pos;
    reg uses_value;

    // decode used for write and read access
    function addr_hit;
        input [15:0] addr;
        begin
            addr_hit = (addr == `REG_ACTION_OPCODE) || (addr == `REG_ACTION_PARAM_ONE) ||
                (addr == `REG_ACTION_PARAM_TWO);
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // bus answer: ack one cycle after any request, err when the address maps nothing
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
        end else begin
            reg_ack <= reg_wr | reg_rd;
            reg_err <= (reg_wr | reg_rd) & ~addr_hit(reg_addr);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // holding registers; every opcode write relaunches, a repeated value too
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            action_opcode <= 16'h0000;
            action_param_one <= 16'h0000;
            action_param_two <= 16'h0000;
            launch <= 1'b0;
            launch_opcode <= 16'h0000;
        end else begin
            launch <= 1'b0;
            // params are taken as written; the launch uses whatever stands then
            if (reg_wr) begin
                case (reg_addr)
                    `REG_ACTION_OPCODE: begin
                        action_opcode <= reg_wdata;
                        launch_opcode <= reg_wdata;
                        launch <= 1'b1;
                    end
                    `REG_ACTION_PARAM_ONE: action_param_one <= reg_wdata;
                    `REG_ACTION_PARAM_TWO: action_param_two <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read path; read data holds until the next read, unmapped reads give zero
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_ACTION_OPCODE: reg_rdata <= action_opcode;
                `REG_ACTION_PARAM_ONE: reg_rdata <= action_param_one;
                `REG_ACTION_PARAM_TWO: reg_rdata <= action_param_two;
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // parameter decode
    io_code_decode u_io_code_decode (
        .point_code(action_param_one),
        .cond_code(action_param_two),
        .point_index(dec_point),
        .point_valid(dec_point_valid),
        .cond_kind(dec_cond)
    );

    //////////////////////////////////////////////////////////////////////////
    // opcode decode; a point/condition opcode with bad codes is rejected
    always @* begin
        next_cmd = 23'h00_0000;
        next_reject = 1'b0;
        uses_point = 1'b0;
        uses_pos = 1'b0;
        uses_value = 1'b0;
        if (launch_opcode[15:8] != 8'h00) begin
            next_reject = 1'b1;
        end else begin
            case (launch_opcode[7:0])
                `OP_ALARM_CLEAR: begin
                    next_cmd[0] = 1'b1;
                end
                `OP_JOG_BEGIN: begin
                    next_cmd[1] = 1'b1;
                end
                `OP_JOG_HALT: begin
                    next_cmd[2] = 1'b1;
                end
                `OP_ENCODER_POS_LOAD: begin
                    next_cmd[3] = 1'b1;
                    uses_pos = 1'b1;
                end
                `OP_FIXED_MOVE_SPEED_CHANGE: begin
                    next_cmd[4] = 1'b1;
                    uses_point = 1'b1;
                end
                `OP_RELATIVE_MOVE: begin
                    next_cmd[5] = 1'b1;
                end
                `OP_SENSOR_MOVE_MASKED: begin
                    next_cmd[6] = 1'b1;
                    uses_point = 1'b1;
                end
                `OP_FIXED_MOVE_WITH_OUTPUT: begin
                    next_cmd[7] = 1'b1;
                    uses_point = 1'b1;
                end
                `OP_ABSOLUTE_MOVE: begin
                    next_cmd[8] = 1'b1;
                end
                `OP_SENSOR_MOVE: begin
                    next_cmd[9] = 1'b1;
                    uses_point = 1'b1;
                end
                `OP_SENSOR_MOVE_SAFETY: begin
                    next_cmd[10] = 1'b1;
                    uses_point = 1'b1;
                end
                `OP_MOTOR_OFF: begin
                    next_cmd[11] = 1'b1;
                end
                `OP_MOTOR_ON: begin
                    next_cmd[12] = 1'b1;
                end
                `OP_ORIGIN_SEEK: begin
                    next_cmd[13] = 1'b1;
                    uses_point = 1'b1;
                end
                `OP_POSITION_LOAD: begin
                    next_cmd[14] = 1'b1;
                    uses_pos = 1'b1;
                end
                `OP_CLOSED_LOOP_SWITCH: begin
                    // only the full closed loop value is a defined mode
                    if (action_param_one == `CLOSED_LOOP_MODE_FULL) begin
                        next_cmd[15] = 1'b1;
                    end else begin
                        next_reject = 1'b1;
                    end
                end
                `OP_SET_OUTPUT: begin
                    next_cmd[16] = 1'b1;
                    uses_point = 1'b1;
                end
                `OP_INPUT_WAIT: begin
                    next_cmd[17] = 1'b1;
                end
                `OP_PROGRAM_RUN: begin
                    next_cmd[18] = 1'b1;
                    uses_value = 1'b1;
                end
                `OP_TIME_WAIT: begin
                    next_cmd[19] = 1'b1;
                    uses_value = 1'b1;
                end
                `OP_ORIGIN_FIND_ALT: begin
                    next_cmd[20] = 1'b1;
                    uses_value = 1'b1;
                end
                `OP_HARD_STOP_FLUSH: begin
                    next_cmd[21] = 1'b1;
                end
                `OP_SOFT_STOP_FLUSH: begin
                    next_cmd[22] = 1'b1;
                end
                default: next_reject = 1'b1;
            endcase
        end
        // a bad point or condition drops the whole launch rather than guess
        // set output needs a level, not an edge
        if (uses_point && (!dec_point_valid || dec_cond == `COND_NONE ||
                (next_cmd[16] && dec_cond != `COND_IS_LOW && dec_cond != `COND_IS_HIGH))) begin
            next_cmd = 23'h00_0000;
            next_reject = 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // strobes, one cycle after the launch; at most one is high in any cycle
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_clear_cmd <= 1'b0;
            jog_begin_cmd <= 1'b0;
            jog_halt_cmd <= 1'b0;
            encoder_pos_load_cmd <= 1'b0;
            fixed_move_speed_change_cmd <= 1'b0;
            relative_move_cmd <= 1'b0;
            sensor_move_masked_cmd <= 1'b0;
            fixed_move_with_output_cmd <= 1'b0;
            absolute_move_cmd <= 1'b0;
            sensor_move_cmd <= 1'b0;
            sensor_move_safety_cmd <= 1'b0;
            motor_off_cmd <= 1'b0;
            motor_on_cmd <= 1'b0;
            origin_seek_cmd <= 1'b0;
            position_load_cmd <= 1'b0;
            closed_loop_switch_cmd <= 1'b0;
            set_output_cmd <= 1'b0;
            input_wait_cmd <= 1'b0;
            program_run_cmd <= 1'b0;
            time_wait_cmd <= 1'b0;
            origin_find_alt_cmd <= 1'b0;
            hard_stop_flush_cmd <= 1'b0;
            soft_stop_flush_cmd <= 1'b0;
            opcode_rejected <= 1'b0;
        end else begin
            alarm_clear_cmd <= launch & next_cmd[0];
            jog_begin_cmd <= launch & next_cmd[1];
            jog_halt_cmd <= launch & next_cmd[2];
            encoder_pos_load_cmd <= launch & next_cmd[3];
            fixed_move_speed_change_cmd <= launch & next_cmd[4];
            relative_move_cmd <= launch & next_cmd[5];
            sensor_move_masked_cmd <= launch & next_cmd[6];
            fixed_move_with_output_cmd <= launch & next_cmd[7];
            absolute_move_cmd <= launch & next_cmd[8];
            sensor_move_cmd <= launch & next_cmd[9];
            sensor_move_safety_cmd <= launch & next_cmd[10];
            motor_off_cmd <= launch & next_cmd[11];
            motor_on_cmd <= launch & next_cmd[12];
            origin_seek_cmd <= launch & next_cmd[13];
            position_load_cmd <= launch & next_cmd[14];
            closed_loop_switch_cmd <= launch & next_cmd[15];
            set_output_cmd <= launch & next_cmd[16];
            input_wait_cmd <= launch & next_cmd[17];
            program_run_cmd <= launch & next_cmd[18];
            time_wait_cmd <= launch & next_cmd[19];
            origin_find_alt_cmd <= launch & next_cmd[20];
            hard_stop_flush_cmd <= launch & next_cmd[21];
            soft_stop_flush_cmd <= launch & next_cmd[22];
            // a launch that fails decode pulses the reject flag instead
            opcode_rejected <= launch & next_reject;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // argument outputs change only on an accepted launch and then hold
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_point <= 4'h0;
            cmd_cond <= `COND_NONE;
            cmd_value <= 16'h0000;
            cmd_position <= 32'h0000_0000;
        end else if (launch && !next_reject) begin
            // unused slots are zeroed, not passed through
            cmd_point <= uses_point ? dec_point : 4'h0;
            cmd_cond <= uses_point ? dec_cond : `COND_NONE;
            cmd_value <= uses_value ? action_param_one : 16'h0000;
            cmd_position <= uses_pos ? {action_param_one, action_param_two} :
                32'h0000_0000;
        end
    end
endmodule // opcode_cmd_interp

// ==== verif/opcode_cmd_interp_assertions.sv ====
// port assertions for the command interpreter
`timescale 1ns/1ps
module opcode_cmd_checker (
    input wire ref_clk,
    input wire reset_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_ack,
    input wire reg_err,
    input wire jog_begin_cmd,
    input wire hard_stop_flush_cmd,
    input wire sensor_move_cmd,
    input wire opcode_rejected
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire req = reg_wr || reg_rd;
    wire mapped = reg_addr >= 16'h9cbd && reg_addr <= 16'h9cbf;
    ////////////////////////////////////////////////////////////////////////
    sequence s_op(v);
        reg_wr && reg_addr == 16'h9cbd && reg_wdata == v;
    endsequence
    sequence s_launch(x);
        ##1 x;
    endsequence
    a_ack_follows_req: assert property (req |=> reg_ack)
        else $error("ack missing after request");
    a_ack_has_cause: assert property (reg_ack |-> $past(req))
        else $error("ack without request");
    a_err_on_unmapped: assert property (req && !mapped |=> reg_err)
        else $error("no error on unmapped address");
    a_err_quiet_mapped: assert property (req && mapped |=> !reg_err)
        else $error("error on mapped address");
    a_jog_launch: assert property (s_op(16'h0096) |=> s_launch(jog_begin_cmd))
        else $error("jog start not launched");
    a_stop_launch: assert property (s_op(16'h00e1) |=> s_launch(hard_stop_flush_cmd))
        else $error("hard stop not launched");
    a_bad_opcode: assert property (s_op(16'h00ff) |=> s_launch(opcode_rejected && !jog_begin_cmd))
        else $error("unknown opcode not rejected");
    a_sensor_cause: assert property (sensor_move_cmd |->
        $past(reg_wr && reg_addr == 16'h9cbd && reg_wdata == 16'h006b, 2))
        else $error("sensor move without its opcode");
endmodule // opcode_cmd_checker

// ==== verif/fieldbus_master_model.sv ====
// register master standing in for the fieldbus side
`timescale 1ns/1ps
module fieldbus_master_model (
    input wire ref_clk,
    input wire reg_ack,
    input wire reg_err,
    input wire [15:0] reg_rdata,
    output reg reg_wr,
    output reg reg_rd,
    output reg [15:0] reg_addr,
    output reg [15:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // one pulsed request, then a bounded wait for ack
    task xfer(input bit wr, input [15:0] a, input [15:0] d,
              output [15:0] q, output e, output ok);
        int n;
        @(posedge ref_clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        // the edge below takes the one-cycle strobe, so it drops right there
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // released lines change, so stale values never look valid
        reg_addr <= ~a;
        reg_wdata <= ~d;
        ok = 1'b0;
        q = 16'h0000;
        e = 1'b0;
        // ack, data and err are taken at the rising edge, before it updates them
        for (n = 0; n < 4 && !ok; n++) begin
            @(posedge ref_clk);
            if (reg_ack === 1'b1) begin
                ok = 1'b1;
                q = reg_rdata;
                e = reg_err;
            end
        end
    endtask
endmodule // fieldbus_master_model

// ==== verif/test_opcode_cmd_interp.sv ====
// self-checking bench for the command interpreter
`timescale 1ns/1ps
module test_opcode_cmd_interp;
    reg ref_clk;
    reg reset_n;
    wire reg_wr, reg_rd, reg_ack, reg_err, opcode_rejected;
    wire [15:0] reg_addr, reg_wdata, reg_rdata, cmd_value;
    wire [3:0] cmd_point;
    wire [2:0] cmd_cond;
    wire [31:0] cmd_position;
    wire [22:0] cmds;
    int errors = 0;
    int cmp_count = 0;
    int i;
    reg [15:0] q;
    reg e, ok;
    logic [7:0] ops [23] = '{8'hba, 8'h96, 8'hd8, 8'h98, 8'h6d, 8'h66, 8'h6a, 8'h68,
        8'h67, 8'h6b, 8'h6c, 8'h9e, 8'h9f, 8'h6e, 8'ha5, 8'h54, 8'h8b, 8'h70, 8'h78,
        8'h6f, 8'hdb, 8'he1, 8'he2};
    logic [7:0] cc [4] = '{8'h4c, 8'h48, 8'h52, 8'h46};
    logic [47:0] bad [6] = '{48'h00ff_0031_004c, 48'h0196_0031_004c, 48'h0054_0002_004c,
        48'h008b_0031_0052, 48'h006b_003d_004c, 48'h006b_0031_0041};
    fieldbus_master_model m (.ref_clk(ref_clk), .reg_ack(reg_ack), .reg_err(reg_err),
        .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    opcode_cmd_interp uut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_err(reg_err), .alarm_clear_cmd(cmds[0]),
        .jog_begin_cmd(cmds[1]), .jog_halt_cmd(cmds[2]), .encoder_pos_load_cmd(cmds[3]),
        .fixed_move_speed_change_cmd(cmds[4]), .relative_move_cmd(cmds[5]),
        .sensor_move_masked_cmd(cmds[6]), .fixed_move_with_output_cmd(cmds[7]),
        .absolute_move_cmd(cmds[8]), .sensor_move_cmd(cmds[9]),
        .sensor_move_safety_cmd(cmds[10]), .motor_off_cmd(cmds[11]),
        .motor_on_cmd(cmds[12]), .origin_seek_cmd(cmds[13]), .position_load_cmd(cmds[14]),
        .closed_loop_switch_cmd(cmds[15]), .set_output_cmd(cmds[16]),
        .input_wait_cmd(cmds[17]), .program_run_cmd(cmds[18]), .time_wait_cmd(cmds[19]),
        .origin_find_alt_cmd(cmds[20]), .hard_stop_flush_cmd(cmds[21]),
        .soft_stop_flush_cmd(cmds[22]), .cmd_point(cmd_point), .cmd_cond(cmd_cond),
        .cmd_value(cmd_value), .cmd_position(cmd_position),
        .opcode_rejected(opcode_rejected));
    ////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string n, input [31:0] exp, input [31:0] got);
        cmp_count++;
        if (exp !== got) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    // a lost ack ends the run rather than hanging it
    task xfer(input bit wr, input [15:0] a, input [15:0] d);
        m.xfer(wr, a, d, q, e, ok);
        if (ok !== 1'b1) begin
            errors++;
            $display("MISMATCH ack expected 1 seen 0");
            final_report;
        end
    endtask
    // params go first so the opcode write finds them in place
    task launch(input [15:0] op, input [15:0] p1, input [15:0] p2);
        xfer(1'b1, 16'h9cbe, p1);
        xfer(1'b1, 16'h9cbf, p2);
        xfer(1'b1, 16'h9cbd, op);
        // strobes land at the edge that returned the ack
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        reset_n = 1'b0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        xfer(1'b1, 16'h9cbe, 16'h1234);
        xfer(1'b1, 16'h9cbf, 16'habcd);
        xfer(1'b1, 16'h9cc0, 16'h5555);
        xfer(1'b0, 16'h9cbe, 16'h0000);
        chk("param one", 17'h0_1234, {e, q});
        xfer(1'b0, 16'h9cbf, 16'h0000);
        chk("param two", 17'h0_abcd, {e, q});
        xfer(1'b0, 16'h9cc0, 16'h0000);
        chk("unmapped read", 17'h1_0000, {e, q});
        for (i = 0; i < 23; i++) begin
            launch({8'h00, ops[i]}, ops[i] == 8'h54 ? 16'h0001 : 16'h0031, 16'h004c);
            chk("strobe", {1'b0, 23'h1 << i}, {opcode_rejected, cmds});
        end
        xfer(1'b0, 16'h9cbd, 16'h0000);
        chk("opcode readback", 16'h00e2, q);
        for (i = 0; i < 6; i++) begin
            launch(bad[i][47:32], bad[i][31:16], bad[i][15:0]);
            chk("reject", 24'h80_0000, {opcode_rejected, cmds});
        end
        for (i = 0; i < 13; i++) begin
            launch(16'h006b, 16'h0030 + i, {8'h00, cc[i % 4]});
            chk("point cond", {i[3:0], 3'(i % 4 + 1)}, {cmd_point, cmd_cond});
        end
        launch(16'h0066, 16'h0031, 16'h0046);
        chk("unused params", 7'h00, {cmd_point, cmd_cond});
        launch(16'h00a5, 16'h1234, 16'h5678);
        chk("position", 32'h1234_5678, cmd_position);
        launch(16'h0098, 16'h8000, 16'h0001);
        chk("encoder position", 32'h8000_0001, cmd_position);
        launch(16'h0078, 16'h0070, 16'h9999);
        chk("program number", 16'h0070, cmd_value);
        launch(16'h00db, 16'h01b3, 16'h0000);
        chk("homing value", 16'h01b3, cmd_value);
        final_report;
    end
endmodule // test_opcode_cmd_interp

bind opcode_cmd_interp opcode_cmd_checker chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .jog_begin_cmd(jog_begin_cmd),
    .hard_stop_flush_cmd(hard_stop_flush_cmd), .sensor_move_cmd(sensor_move_cmd),
    .opcode_rejected(opcode_rejected));
